/* File: shared/rtcsp_cfg.svh */
// Purpose: constants of the rtc serial port and clock trim
// Assumes: included by its bare name
// Notes: trim periods are counted in oscillator ticks
`ifndef RTCSP_CFG_SVH
`define RTCSP_CFG_SVH
// command byte: fixed nibble, group, select, direction
`define RTCSP_CMD_FIXED 4'h6
`define RTCSP_GRP_STAT 2'h0
`define RTCSP_GRP_TIME 2'h1
`define RTCSP_GRP_INT 2'h2
`define RTCSP_GRP_AUX 2'h3
`define RTCSP_DIR_READ 1'b1
`define RTCSP_BIT_LAST 3'h7
`define RTCSP_BYTE_SAT 2'h3
`define RTCSP_LEN_ONE 2'h1
`define RTCSP_LEN_ALARM 2'h3
`define RTCSP_RST_BYTE 8'h00
// status register fields
`define RTCSP_S1_STEP 0
`define RTCSP_S2_SECOND_ALARM 1
`define RTCSP_S2_USER_FREQ 4
`define RTCSP_S2_FIRST_ALARM 5
// trim: oscillator ticks per second and group lengths
`define RTCSP_TICKS_NOM 16'h8000
`define RTCSP_TICKS_HALF 16'h4000
`define RTCSP_TICKS_MIN 16'h7f82
`define RTCSP_TICKS_MAX 16'h8080
`define RTCSP_TICK_ONE 16'h0001
`define RTCSP_GROUP_LAST_M0 6'h13
`define RTCSP_GROUP_LAST_M1 6'h3b
`define RTCSP_SEC_ZERO 6'h00
`define RTCSP_SEC_ONE 6'h01
`endif

/* File: shared/rtcsp_pkg.sv */
// Purpose: shared types of the rtc serial port
// Assumes: nothing
// Notes: pin and configuration groups travel as structs
`default_nettype none
package rtcsp_pkg;
  // port state machine
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_READ, ST_WRITE, ST_SKIP} rtcsp_state_t;
  // raw pins from outside the clock domain
  typedef struct packed {
    logic osc;
    logic serial_data_io;
    logic sck;
    logic cs;
  } rtcsp_pins_t;
  // decoded interrupt data for the alarm and output logic
  typedef struct packed {
    logic first_alarm_en;
    logic second_alarm_en;
    logic user_freq_en;
    logic [23:0] alarm1;
    logic [23:0] alarm2;
    logic [7:0] freq;
  } rtcsp_cfg_t;
endpackage
`default_nettype wire

/* File: core/rtcsp_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rtcsp_sync
  import rtcsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire rtcsp_pins_t pins_in,
  output rtcsp_pins_t pins_out
);
  // stage flops, one column per pin
  logic [3:0] s1_q, s2_q, s3_q, o_q;
  // per pin: change accepted once stages two and three agree
  for (genvar i = 0; i < 4; i++) begin : g_pin
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        o_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pins_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        // disagreement holds the last accepted level
        if (s2_q[i] == s3_q[i]) begin
          o_q[i] <= s3_q[i];
        end
      end
    end
  end
  assign pins_out = o_q;
endmodule
`default_nettype wire

/* File: core/rtcsp_trim.sv */
// Purpose: 1 Hz divider with digital trim
// Assumes: osc_tick pulses once per oscillator rising edge
// Notes: only the tick count moves, never the oscillator
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_cfg.svh"
module rtcsp_trim
  import rtcsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic osc_tick,
  input wire logic [7:0] trim_setting,
  output logic one_hz_out,
  output logic step_pulse
);
  logic [6:0] val; // signed step count, bit order reversed
  logic mode; // trim mode bit
  logic [5:0] last; // last period index of a group
  logic [15:0] lim; // ticks in the current period
  logic per_end; // final tick of a period
  logic [15:0] tick_q;
  logic [5:0] sec_q;
  logic hz_q;

  for (genvar i = 0; i < 7; i++) begin : g_rev
    assign val[i] = trim_setting[7 - i];
  end
  assign mode = trim_setting[0];
  assign last = mode ? `RTCSP_GROUP_LAST_M1 : `RTCSP_GROUP_LAST_M0;
  // two ticks per step, zero gives nominal
  assign lim = (sec_q == `RTCSP_SEC_ZERO) ? `RTCSP_TICKS_NOM - {{8{val[6]}}, val, 1'b0} : `RTCSP_TICKS_NOM;
  // a setting change mid period must not strand the counter
  assign per_end = osc_tick && (tick_q >= lim - `RTCSP_TICK_ONE);
  assign step_pulse = per_end && (sec_q == `RTCSP_SEC_ZERO) && (val != 7'h00);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 16'h0000;
    end else if (per_end) begin
      tick_q <= 16'h0000;
    end else if (osc_tick) begin
      tick_q <= tick_q + `RTCSP_TICK_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_q <= `RTCSP_SEC_ZERO;
    end else if (per_end) begin
      sec_q <= (sec_q >= last) ? `RTCSP_SEC_ZERO : sec_q + `RTCSP_SEC_ONE;
    end
  end

  // high for the first RTCSP_TICKS_HALF ticks of each period, low for the rest
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hz_q <= 1'b0;
    end else begin
      hz_q <= (tick_q < `RTCSP_TICKS_HALF);
    end
  end
  assign one_hz_out = hz_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_GROUP_WRAP: assert property ((per_end && sec_q >= last) |=> sec_q == `RTCSP_SEC_ZERO)
    else $error("trim group did not wrap");
  AST_PLAIN_PERIOD: assert property ((sec_q != `RTCSP_SEC_ZERO) |-> lim == `RTCSP_TICKS_NOM)
    else $error("uncorrected period altered");
  AST_STEP_RANGE: assert property (lim >= `RTCSP_TICKS_MIN && lim <= `RTCSP_TICKS_MAX)
    else $error("trim period out of range");
  AST_ZERO_NONE: assert property ((val == 7'h00 && per_end) |-> !step_pulse)
    else $error("zero setting corrected");
endmodule
`default_nettype wire

/* File: core/rtcsp_top.sv */
// Purpose: 3-wire serial command port and trim of an rtc
// Assumes: pins asynchronous, sampled three deep on ref_clk
// Notes: command sent first bit first, data bytes lsb first
// Operation
// - direction one enters read, drives on falls
// - direction zero enters write, stores bytes
// - under eight edges: wait, no processing
// - select bit picks status one or two
// - interrupt data one: alarm, frequency or byte
// - second alarm enable makes three-byte register
// - interrupt data two has no frequency
// - mode zero: 3.052 ppm reversed signed steps
// - mode one: 1.017 ppm steps, zero none
// - trim moves divider, never the oscillator
// - one period in 20 or 60 altered
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_cfg.svh"
module rtcsp_top
  import rtcsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_in,
  input wire logic sck_in,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe_n,
  input wire logic osc_in,
  output logic clk32k_out,
  output logic one_hz_out,
  output rtcsp_cfg_t cfg_out
);
  rtcsp_pins_t pins_raw; // pins before the synchroniser
  rtcsp_pins_t pins_s; // filtered pins
  logic sck_prev_q, osc_prev_q; // edge history
  logic sck_rise, sck_fall, osc_tick;
  rtcsp_state_t state_q, state_d;
  logic [2:0] bit_q; // bit within the byte
  logic [1:0] byte_q; // byte within the transfer
  logic [7:0] cmd_q; // command shift register
  logic [7:0] wsh_q; // write data shift register
  logic sio_q; // read data flop
  logic [7:0] stat1_q, stat2_q, trim_q, free_q;
  logic [2:0][7:0] int1_q, int2_q; // interrupt data bytes
  logic step_flag_q; // sticky trim step seen
  logic step_pulse;
  logic cmd_done, fixed_ok, byte_done, wr_en, stat1_clr;
  logic [7:0] wr_byte, rd_byte, stat1_view;
  logic rd_bit;
  logic [1:0] grp; // register group of the command
  logic sel; // select bit of the command
  logic [1:0] len; // byte length of the addressed register
  logic int1_alarm, int2_alarm, user_freq;
  rtcsp_cfg_t cfg_q;

  assign pins_raw = '{osc: osc_in, serial_data_io: serial_data_io_in, sck: sck_in, cs: cs_in};

  rtcsp_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  // edge history of the filtered clocks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= pins_s.sck;
      osc_prev_q <= pins_s.osc;
    end
  end
  assign sck_rise = pins_s.sck && !sck_prev_q;
  assign sck_fall = !pins_s.sck && sck_prev_q;
  assign osc_tick = pins_s.osc && !osc_prev_q;

  // command decode; fields settle once the byte is in
  assign fixed_ok = (cmd_q[6:3] == `RTCSP_CMD_FIXED);
  assign cmd_done = (state_q == ST_CMD) && sck_rise && (bit_q == `RTCSP_BIT_LAST);
  assign grp = cmd_q[3:2];
  assign sel = cmd_q[1];
  assign int1_alarm = stat2_q[`RTCSP_S2_FIRST_ALARM];
  assign int2_alarm = stat2_q[`RTCSP_S2_SECOND_ALARM];
  assign user_freq = stat2_q[`RTCSP_S2_USER_FREQ];

  // next state; deselect always wins
  always_comb begin
    state_d = state_q;
    if (!pins_s.cs) begin
      state_d = ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_d = ST_CMD;
        end
        ST_CMD: begin
          if (cmd_done) begin
            // a foreign command is clocked through silently
            if (!fixed_ok) begin
              state_d = ST_SKIP;
            end else if (pins_s.serial_data_io == `RTCSP_DIR_READ) begin
              state_d = ST_READ;
            end else begin
              state_d = ST_WRITE;
            end
          end
        end
        ST_READ, ST_WRITE, ST_SKIP: begin
          state_d = state_q;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // bit and byte counters; bytes saturate past the last
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_q <= 3'h0;
      byte_q <= 2'h0;
    end else if (state_q == ST_IDLE || cmd_done) begin
      bit_q <= 3'h0;
      byte_q <= 2'h0;
    end else if ((state_q != ST_READ && sck_rise) || (state_q == ST_READ && sck_fall)) begin
      bit_q <= bit_q + 3'h1;
      if (bit_q == `RTCSP_BIT_LAST && byte_q != `RTCSP_BYTE_SAT) begin
        byte_q <= byte_q + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= `RTCSP_RST_BYTE;
    end else if (state_q == ST_CMD && sck_rise) begin
      cmd_q <= {cmd_q[6:0], pins_s.serial_data_io};
    end
  end

  assign wr_byte = {pins_s.serial_data_io, wsh_q[7:1]};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wsh_q <= `RTCSP_RST_BYTE;
    end else if (state_q == ST_WRITE && sck_rise) begin
      wsh_q <= wr_byte;
    end
  end

  // byte length of the addressed register
  always_comb begin
    len = `RTCSP_LEN_ONE;
    if (grp == `RTCSP_GRP_INT && !sel && int1_alarm) begin
      len = `RTCSP_LEN_ALARM;
    end
    if (grp == `RTCSP_GRP_INT && sel && int2_alarm) begin
      len = `RTCSP_LEN_ALARM;
    end
  end
  // surplus bytes from the master are dropped
  assign byte_done = (state_q == ST_WRITE) && sck_rise && (bit_q == `RTCSP_BIT_LAST);
  assign wr_en = byte_done && (byte_q < len);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat1_q <= `RTCSP_RST_BYTE;
      stat2_q <= `RTCSP_RST_BYTE;
    end else if (wr_en && grp == `RTCSP_GRP_STAT) begin
      if (sel) begin
        stat2_q <= wr_byte;
      end else begin
        stat1_q <= wr_byte;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int1_q <= '0;
      int2_q <= '0;
    end else if (wr_en && grp == `RTCSP_GRP_INT) begin
      if (sel) begin
        int2_q[byte_q] <= wr_byte;
      end else begin
        int1_q[byte_q] <= wr_byte;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_q <= `RTCSP_RST_BYTE;
      free_q <= `RTCSP_RST_BYTE;
    end else if (wr_en && grp == `RTCSP_GRP_AUX) begin
      if (sel) begin
        free_q <= wr_byte;
      end else begin
        trim_q <= wr_byte;
      end
    end
  end

  // step flag: set wins over the clear after a full read
  assign stat1_clr = (state_q == ST_READ) && !pins_s.cs && (grp == `RTCSP_GRP_STAT) && !sel && (byte_q != 2'h0);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_flag_q <= 1'b0;
    end else begin
      step_flag_q <= step_pulse || (step_flag_q && !stat1_clr);
    end
  end

  // read data; real-time data lives elsewhere and reads zero
  always_comb begin
    stat1_view = stat1_q;
    stat1_view[`RTCSP_S1_STEP] = step_flag_q;
    rd_byte = `RTCSP_RST_BYTE;
    if (byte_q < len) begin
      unique case (grp)
        `RTCSP_GRP_STAT: rd_byte = sel ? stat2_q : stat1_view;
        `RTCSP_GRP_TIME: rd_byte = `RTCSP_RST_BYTE;
        `RTCSP_GRP_INT: rd_byte = sel ? int2_q[byte_q] : int1_q[byte_q];
        `RTCSP_GRP_AUX: rd_byte = sel ? free_q : trim_q;
      endcase
    end
  end
  assign rd_bit = rd_byte[bit_q];

  // drive on each fall in read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sio_q <= 1'b0;
    end else if (state_q != ST_READ) begin
      sio_q <= 1'b0;
    end else if (sck_fall) begin
      sio_q <= rd_bit;
    end
  end
  assign serial_data_io_out = sio_q;
  assign serial_data_io_oe_n = (state_q != ST_READ);

  // decoded view for the alarm and output logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= '0;
    end else begin
      cfg_q.first_alarm_en <= int1_alarm;
      cfg_q.second_alarm_en <= int2_alarm;
      cfg_q.user_freq_en <= user_freq;
      cfg_q.alarm1 <= int1_alarm ? int1_q : 24'h000000;
      cfg_q.alarm2 <= int2_alarm ? int2_q : 24'h000000;
      // frequency only from the first register
      cfg_q.freq <= user_freq ? int1_q[0] : `RTCSP_RST_BYTE;
    end
  end
  assign cfg_out = cfg_q;

  assign clk32k_out = pins_s.osc;

  rtcsp_trim u_trim (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .osc_tick(osc_tick),
    .trim_setting(trim_q),
    .one_hz_out(one_hz_out),
    .step_pulse(step_pulse)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_cmd_read;
    cmd_done && fixed_ok && pins_s.cs && pins_s.serial_data_io;
  endsequence
  sequence s_cmd_write;
    cmd_done && fixed_ok && pins_s.cs && !pins_s.serial_data_io;
  endsequence
  AST_ENTER_READ: assert property (s_cmd_read |=> state_q == ST_READ && !serial_data_io_oe_n)
    else $error("read state not entered");
  AST_ENTER_WRITE: assert property (s_cmd_write |=> state_q == ST_WRITE && serial_data_io_oe_n)
    else $error("write state not entered");
  AST_CLOCK_WAIT: assert property ((state_q == ST_CMD) |-> !wr_en && serial_data_io_oe_n)
    else $error("processing before eight edges");
  AST_READ_SHIFT: assert property ((state_q == ST_READ && pins_s.cs && sck_fall) |=> serial_data_io_out == $past(rd_bit))
    else $error("read bit not driven");
  AST_DRIVE_ONLY_READ: assert property (!serial_data_io_oe_n |-> state_q == ST_READ)
    else $error("data line driven outside read");
  AST_RELEASE_DESELECT: assert property (!pins_s.cs |=> serial_data_io_oe_n)
    else $error("data line held after deselect");
  AST_STATUS_SELECT: assert property ((wr_en && grp == `RTCSP_GRP_STAT && sel) |=> stat2_q == $past(wr_byte) && $stable(stat1_q))
    else $error("wrong status register written");
  AST_INT1_LENGTH: assert property ((grp == `RTCSP_GRP_INT && !sel) |-> len == (int1_alarm ? `RTCSP_LEN_ALARM : `RTCSP_LEN_ONE))
    else $error("first interrupt length wrong");
  AST_INT2_LENGTH: assert property ((grp == `RTCSP_GRP_INT && sel) |-> len == (int2_alarm ? `RTCSP_LEN_ALARM : `RTCSP_LEN_ONE))
    else $error("second interrupt length wrong");
  AST_NO_FREQ_TWO: assert property ((wr_en && grp == `RTCSP_GRP_INT && sel) |-> ##2 $stable(cfg_out.freq))
    else $error("frequency moved by second register");
endmodule
`default_nettype wire

/* File: tb/rtcsp_host.sv */
// Purpose: host master model that drives the 3-wire command port
// Assumes: link clock idles high and stands still between frames
// Notes: each link clock level lasts six ref_clk cycles; a 12.5 cycle
//   period cannot be made on ref_clk edges, so the period is 120 ns, not 125 ns
`timescale 1ns/1ps
`default_nettype none
module rtcsp_host (
  input wire logic ref_clk,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  output logic cs,
  output logic sck,
  output logic sio_line
);
  logic drv = 1'b0; // host owns the data line
  logic val = 1'b0; // host drive value
  int unsigned oe_seen = 0; // cycles with the device driving
  int unsigned clash = 0; // cycles with both parties driving
  // select low and link clock parked high from time zero
  initial begin
    cs = 1'b0;
    sck = 1'b1;
  end
  // wire resolved from both enables
  // a released line shows the inverse of the last host bit, so a late sample is caught
  assign sio_line = !dev_oe_n ? dev_out : (drv ? val : ~val);
  // count device drive and cycles where both parties drive
  always @(posedge ref_clk) begin
    if (!dev_oe_n) begin
      oe_seen <= oe_seen + 1;
      if (drv) begin
        clash <= clash + 1;
      end
    end
  end
  // data changes on fall, sampled on rise
  task automatic bit_io(input logic b, input logic own, input logic rel, output logic got);
    sck <= 1'b0;
    val <= b;
    drv <= own;
    repeat (6) @(posedge ref_clk);
    sck <= 1'b1;
    // hold the bit past the rise, then hand the line over before the device drives it
    repeat (2) @(posedge ref_clk);
    if (rel) begin
      drv <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    got = sio_line;
  endtask
  // exactly the register length is clocked
  task automatic frame(input logic [7:0] cmd, input int ncmd, input int nbytes,
                       input logic [23:0] wdata, output logic [23:0] rdata, output int oe_cnt);
    logic got;
    int unsigned start;
    rdata = 24'h000000;
    @(posedge ref_clk);
    start = oe_seen;
    cs <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < ncmd; i++) begin
      bit_io(cmd[7 - i], 1'b1, i == 7 && cmd[0], got);
    end
    for (int i = 0; i < 8 * nbytes; i++) begin
      bit_io(wdata[i], ~cmd[0], 1'b0, got);
      rdata[i] = got;
    end
    cs <= 1'b0;
    drv <= 1'b0;
    repeat (8) @(posedge ref_clk);
    oe_cnt = int'(oe_seen - start);
  endtask
endmodule
`default_nettype wire

/* File: tb/rtc_serial_port_and_trim_bench.sv */
// Purpose: self-checking bench of the rtc serial port and trim
// Assumes: the host model makes every frame; the oscillator runs fast here
// Notes: a trim group spans millions of cycles, so only pass-through of the
//   oscillator is timed; group lengths are left to the in-design assertions
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_cfg.svh"
module rtc_serial_port_and_trim_bench
  import rtcsp_pkg::*;
;
  logic ref_clk = 1'b0; // 100 MHz system clock
  logic arst_n = 1'b0; // held low at start
  logic osc_in = 1'b0; // sped-up oscillator
  logic run = 1'b0; // pass-through checks armed
  logic cs, sck, sio_line, dev_out, dev_oe_n, clk32k_out, one_hz_out;
  rtcsp_cfg_t cfg_out;
  int n_errors = 0;
  int n_compared = 0;
  int osc_cnt = 0;
  rtcsp_top dut_u (.ref_clk, .arst_n, .cs_in(cs), .sck_in(sck), .serial_data_io_in(sio_line),
    .serial_data_io_out(dev_out), .serial_data_io_oe_n(dev_oe_n), .osc_in, .clk32k_out,
    .one_hz_out, .cfg_out);
  rtcsp_host host_u (.ref_clk, .dev_out, .dev_oe_n, .cs, .sck, .sio_line);
  // free-running clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // single compare point
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one framed transfer with a well-formed command byte
  task automatic xfer(input logic [1:0] g, input logic s, input logic r, input int n,
                      input logic [23:0] w, output logic [23:0] q, output int oe);
    host_u.frame({`RTCSP_CMD_FIXED, g, s, r}, 8, n, w, q, oe);
  endtask
  // oscillator toggles every 8 cycles; its level is compared late in each half
  always @(posedge ref_clk) begin
    osc_cnt <= (osc_cnt + 1) % 8;
    if (osc_cnt == 7) begin
      osc_in <= ~osc_in;
    end
    if (osc_cnt == 6 && run) begin
      check(64'(clk32k_out), 64'(osc_in));
    end
  end
  task automatic t_reset();
    logic [23:0] q;
    int oe;
    check(64'(cfg_out), 64'h0);
    check(64'(dev_oe_n), 64'h1);
    check(64'(one_hz_out), 64'h1);
    xfer(`RTCSP_GRP_AUX, 1'b0, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h0);
    xfer(`RTCSP_GRP_STAT, 1'b1, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h0);
    $display("test reset done");
  endtask
  // endpoints of both correction tables and the mode-one zero
  // zeros written last since trim stays unused
  task automatic t_trim();
    logic [7:0] codes [6] = '{8'hfc, 8'h02, 8'hfd, 8'h03, 8'h01, 8'h00};
    logic [23:0] q;
    int oe;
    foreach (codes[i]) begin
      xfer(`RTCSP_GRP_AUX, 1'b0, 1'b0, 1, 24'(codes[i]), q, oe);
      check(64'(oe), 64'h0);
      xfer(`RTCSP_GRP_AUX, 1'b0, 1'b1, 1, 24'h0, q, oe);
      check(64'(q), 64'(codes[i]));
      check(64'(oe > 0), 64'h1);
    end
    // free byte shares the aux group and must not touch the trim
    xfer(`RTCSP_GRP_AUX, 1'b1, 1'b0, 1, 24'h5c, q, oe);
    xfer(`RTCSP_GRP_AUX, 1'b1, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h5c);
    xfer(`RTCSP_GRP_AUX, 1'b0, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h0);
    $display("test trim done");
  endtask
  // status two set before interrupt one
  task automatic t_status();
    logic [23:0] q;
    int oe;
    xfer(`RTCSP_GRP_STAT, 1'b1, 1'b0, 1, 24'h22, q, oe);
    check(64'({cfg_out.first_alarm_en, cfg_out.second_alarm_en, cfg_out.user_freq_en}), 64'h6);
    // status one written with select zero; bit0 shows the idle step flag
    xfer(`RTCSP_GRP_STAT, 1'b0, 1'b0, 1, 24'h84, q, oe);
    xfer(`RTCSP_GRP_STAT, 1'b0, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h84);
    xfer(`RTCSP_GRP_STAT, 1'b1, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h22);
    xfer(`RTCSP_GRP_INT, 1'b0, 1'b0, 3, 24'h123456, q, oe);
    xfer(`RTCSP_GRP_INT, 1'b1, 1'b0, 3, 24'habcdef, q, oe);
    check(64'({cfg_out.alarm1, cfg_out.alarm2}), 64'h123456abcdef);
    xfer(`RTCSP_GRP_INT, 1'b0, 1'b1, 3, 24'h0, q, oe);
    check(64'(q), 64'h123456);
    xfer(`RTCSP_GRP_INT, 1'b1, 1'b1, 3, 24'h0, q, oe);
    check(64'(q), 64'habcdef);
    $display("test status done");
  endtask
  // frequency output with first alarm off
  task automatic t_freq();
    logic [23:0] q;
    int oe;
    xfer(`RTCSP_GRP_STAT, 1'b1, 1'b0, 1, 24'h10, q, oe);
    xfer(`RTCSP_GRP_INT, 1'b0, 1'b0, 1, 24'ha5, q, oe);
    check(64'({cfg_out.alarm1, cfg_out.freq}), 64'ha5);
    xfer(`RTCSP_GRP_INT, 1'b1, 1'b0, 1, 24'h5a, q, oe);
    check(64'({cfg_out.alarm2, cfg_out.freq}), 64'ha5);
    xfer(`RTCSP_GRP_INT, 1'b0, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'ha5);
    $display("test freq done");
  endtask
  // short and malformed commands must leave everything alone
  task automatic t_refuse();
    logic [23:0] q;
    int oe;
    host_u.frame(8'h6d, 7, 0, 24'h0, q, oe);
    check(64'(oe), 64'h0);
    host_u.frame(8'h6c, 7, 0, 24'h0, q, oe);
    check(64'(oe), 64'h0);
    host_u.frame(8'h7d, 8, 1, 24'h0, q, oe);
    check(64'(oe), 64'h0);
    host_u.frame(8'h7c, 8, 1, 24'hff, q, oe);
    xfer(`RTCSP_GRP_AUX, 1'b0, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h0);
    xfer(`RTCSP_GRP_TIME, 1'b0, 1'b1, 1, 24'h0, q, oe);
    check(64'(q), 64'h0);
    check(64'(host_u.clash), 64'h0);
    $display("test refuse done");
  endtask
  // reset for ten cycles, then run every scenario
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    run <= 1'b1;
    t_reset();
    t_trim();
    t_status();
    t_freq();
    t_refuse();
    tally_and_finish();
  end
  // hang guard: a run that outlives its bound is a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
